// ---- rtl/ldd_pkg.sv ----
// Constants and types shared by the LED driver diagnostics block.
package ldd_pkg;
  localparam int CLK_NS = 5;
  localparam int STEP_NS = 200;
  localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int OPEN_NS = 50000;
  localparam int OPEN_CYC = OPEN_NS / CLK_NS;
  localparam int INIT_NS = 150000;
  localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int NCH = 2;

  localparam logic [7:0] A_CTRL = 8'h10;
  localparam logic [7:0] A_TW_THR = 8'h11;
  localparam logic [7:0] A_FORCE = 8'h12;
  localparam logic [7:0] A_STR_FAULT = 8'h13;
  localparam logic [7:0] A_DEV_FAULT = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h15;
  localparam logic [7:0] A_TEMP = 8'h16;
  localparam logic [7:0] A_VON1 = 8'h17;
  localparam logic [7:0] A_V1 = 8'h19;
  localparam logic [7:0] A_TON1 = 8'h1b;

  localparam logic [7:0] TW_THR_RST = 8'hb3;
  localparam logic [8:0] ADC_RST = 9'h100;
  localparam logic [2:0] FSM_RESET_0 = 3'h0;
  localparam logic [2:0] FSM_RESET_1 = 3'h1;
  localparam logic [2:0] FSM_SA_0 = 3'h6;
  localparam logic [2:0] FSM_SA_1 = 3'h7;

  typedef enum logic [2:0] {
    SRC_TEMP = 3'b000,
    SRC_VON1 = 3'b001,
    SRC_VON2 = 3'b010,
    SRC_V1 = 3'b011,
    SRC_V2 = 3'b100
  } ldd_src_t;

  typedef enum logic [1:0] {
    M_INIT = 2'b00,
    M_NORMAL = 2'b01,
    M_STANDALONE = 2'b10,
    M_FAILSAFE = 2'b11
  } ldd_mode_t;

  // Parity in bit 8, value in bits 7:0.
  typedef struct packed {
    logic par;
    logic [7:0] val;
  } ldd_adc_t;

  typedef struct packed {
    logic [1:0] min_ton;
    logic [1:0] oc;
    logic [1:0] shrt;
    logic [1:0] open;
  } ldd_str_flags_t;

  typedef struct packed {
    logic por;
    logic serr;
    logic thermal_shutdown_flag;
    logic tw;
  } ldd_dev_flags_t;

  typedef struct packed {
    logic [1:0] oc_lim2;
    logic [1:0] oc_lim1;
    logic [1:0] rng2;
    logic [1:0] rng1;
    logic [1:0] auto_rcv;
    logic [1:0] en;
  } ldd_ctrl_t;
endpackage

// ---- rtl/ldd_debounce.sv ----
// Debouncers for the two dimming control inputs.
`timescale 1ns/1ps
module ldd_debounce
  import ldd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Raw and filtered levels
  input wire logic [NCH-1:0] i_raw,
  output logic [NCH-1:0] o_level
);
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [5:0] cnt_q;
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        cnt_q <= '0;
        o_level[c] <= 1'b0;
      end else if (i_raw[c] == o_level[c]) begin
        cnt_q <= '0;
      end else if (cnt_q == 6'(STEP_CYC - 1)) begin
        cnt_q <= '0;
        o_level[c] <= i_raw[c];
      end else begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end
endmodule

// ---- rtl/ldd_on_timer.sv ----
// Per-channel on-time measurement and open-string overflow detection.
`timescale 1ns/1ps
module ldd_on_timer
  import ldd_pkg::*;
#(
  parameter int OPEN_LIMIT = OPEN_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_clr,
  // Switch state
  input wire logic [NCH-1:0] i_gate_on,
  input wire logic [NCH-1:0] i_active,
  // Results
  output logic [NCH-1:0] o_open,
  output logic [NCH-1:0][7:0] o_ton
);
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [5:0] sub_q;
    logic [8:0] steps_q;
    logic [15:0] run_q;
    logic gate_q;
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        sub_q <= '0;
        steps_q <= '0;
        run_q <= '0;
        gate_q <= 1'b0;
        o_ton[c] <= '0;
        o_open[c] <= 1'b0;
      end else if (i_clr) begin
        sub_q <= '0;
        steps_q <= '0;
        run_q <= '0;
        gate_q <= 1'b0;
        o_ton[c] <= '0;
        o_open[c] <= 1'b0;
      end else begin
        gate_q <= i_gate_on[c];
        o_open[c] <= 1'b0;
        if (i_gate_on[c]) begin
          sub_q <= (sub_q == 6'(STEP_CYC - 1)) ? 6'h00 : sub_q + 6'h01;
          if (sub_q == 6'(STEP_CYC - 1) && !steps_q[8]) begin
            steps_q <= steps_q + 9'h001;
          end
          if (run_q != 16'(OPEN_LIMIT)) begin
            run_q <= run_q + 16'h0001;
          end
          o_open[c] <= i_active[c] && run_q == 16'(OPEN_LIMIT - 1);
        end else begin
          sub_q <= '0;
          steps_q <= '0;
          run_q <= '0;
        end
        if (gate_q && !i_gate_on[c]) begin
          o_ton[c] <= steps_q[8] ? 8'hff : steps_q[7:0];
        end
      end
    end
  end
endmodule

// ---- rtl/ldd_diag.sv ----
// Diagnostics, result storage and mode control of the dual LED driver.
`timescale 1ns/1ps
module ldd_diag
  import ldd_pkg::*;
#(
  parameter int OPEN_LIMIT = OPEN_CYC,
  parameter int INIT_LIMIT = INIT_CYC,
  parameter bit ZERO_CROSS_VARIANT = 1'b0
) (
  // Clock and power-on reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Reset pin and one-time memory
  input wire logic i_reset_pin_n,
  input wire logic [2:0] i_failsafe_mode_sel,
  input wire logic i_otp_lock,
  // Register access from the serial interface
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_serial_err,
  output logic [15:0] o_reg_rdata,
  // Converter results and sequence timing
  input wire logic i_adc_valid,
  input wire ldd_src_t i_adc_src,
  input wire logic [7:0] i_adc_data,
  input wire logic i_seq_done,
  input wire logic [7:0] i_tsd_code,
  // Channel analog status
  input wire logic [NCH-1:0] i_dim_control_input,
  input wire logic [NCH-1:0] i_gate_on,
  input wire logic [NCH-1:0] i_short_cmp,
  input wire logic [NCH-1:0] i_zero_cross,
  input wire logic [NCH-1:0] i_oc_tick,
  input wire logic [NCH-1:0] i_oc_above,
  input wire logic [NCH-1:0] i_min_ton,
  // Channel controls
  output logic [NCH-1:0] o_buck_run,
  output logic [NCH-1:0] o_short_toff,
  output logic [NCH-1:0] o_force_sample,
  output logic [NCH-1:0][1:0] o_string_volt_range_sel,
  output ldd_mode_t o_mode
);
  ldd_ctrl_t ctrl_q;
  logic [7:0] temp_warn_threshold_q;
  logic [8:0] forced_sample_period_q;
  ldd_str_flags_t str_q;
  ldd_dev_flags_t dev_q;
  ldd_adc_t die_temp_code_q;
  ldd_adc_t [NCH-1:0] string_volt_on_sample_q;
  ldd_adc_t [NCH-1:0] string_volt_sample_q;
  logic [NCH-1:0] dim_lvl;
  logic [NCH-1:0] dim_lvl_q;
  logic [NCH-1:0] open_evt;
  logic [NCH-1:0][7:0] on_time_measure;
  logic [NCH-1:0] oc_off_q;
  logic [NCH-1:0][2:0] oc_cnt_q;
  logic [NCH-1:0][8:0] force_cnt_q;
  logic [NCH-1:0] tsd_hold_q;
  logic [NCH-1:0] en_prev_q;
  logic [NCH-1:0] regulating;
  logic tsd_active_q;
  logic pin_q;
  logic soft_rst_q;
  logic [15:0] init_cnt_q;
  logic rd_str;
  logic rd_dev;
  logic temp_ge_thr;
  logic [NCH-1:0] ch_ok;

  ldd_debounce i_ldd_debounce (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_raw(i_dim_control_input),
    .o_level(dim_lvl)
  );

  ldd_on_timer #(.OPEN_LIMIT(OPEN_LIMIT)) i_ldd_on_timer (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clr(soft_rst_q),
    .i_gate_on(i_gate_on),
    .i_active(o_buck_run),
    .o_open(open_evt),
    .o_ton(on_time_measure)
  );

  assign rd_str = i_reg_rd && i_reg_addr == A_STR_FAULT;
  assign rd_dev = i_reg_rd && i_reg_addr == A_DEV_FAULT;
  assign temp_ge_thr = die_temp_code_q.val >= temp_warn_threshold_q;
  assign regulating = o_buck_run & i_gate_on;

  // A reset-pin fall resets only in the reset and standalone mode selections, and never in failsafe mode.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_q <= 1'b1;
      soft_rst_q <= 1'b0;
    end else begin
      pin_q <= i_reset_pin_n;
      soft_rst_q <= pin_q && !i_reset_pin_n && o_mode != M_FAILSAFE &&
                    (i_failsafe_mode_sel == FSM_RESET_0 || i_failsafe_mode_sel == FSM_RESET_1 ||
                     i_failsafe_mode_sel == FSM_SA_0 || i_failsafe_mode_sel == FSM_SA_1);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mode <= M_INIT;
      init_cnt_q <= '0;
    end else if (soft_rst_q) begin
      o_mode <= M_INIT;
      init_cnt_q <= '0;
    end else begin
      unique case (o_mode)
        M_INIT: begin
          init_cnt_q <= init_cnt_q + 16'h0001;
          if (init_cnt_q == 16'(INIT_LIMIT - 1)) begin
            o_mode <= (i_otp_lock && i_failsafe_mode_sel[2:1] == FSM_SA_0[2:1]) ?
                      M_STANDALONE : M_NORMAL;
          end
        end
        M_NORMAL: begin
          if (pin_q && !i_reset_pin_n && i_otp_lock && i_failsafe_mode_sel != FSM_RESET_0 &&
              i_failsafe_mode_sel != FSM_RESET_1 && i_failsafe_mode_sel[2:1] != FSM_SA_0[2:1]) begin
            o_mode <= M_FAILSAFE;
          end
        end
        M_STANDALONE: o_mode <= M_STANDALONE;
        M_FAILSAFE: begin
          if (!pin_q && i_reset_pin_n) begin
            o_mode <= M_NORMAL;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= '0;
      temp_warn_threshold_q <= TW_THR_RST;
      forced_sample_period_q <= '0;
    end else if (soft_rst_q) begin
      ctrl_q <= '0;
      temp_warn_threshold_q <= TW_THR_RST;
      forced_sample_period_q <= '0;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        A_CTRL: ctrl_q <= ldd_ctrl_t'(i_reg_wdata[11:0]);
        A_TW_THR: temp_warn_threshold_q <= i_reg_wdata[7:0];
        A_FORCE: forced_sample_period_q <= i_reg_wdata[8:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Results keep odd parity so software can check each read.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      die_temp_code_q <= ADC_RST;
      string_volt_on_sample_q <= {NCH{ADC_RST}};
      string_volt_sample_q <= {NCH{ADC_RST}};
    end else if (i_adc_valid) begin
      unique case (i_adc_src)
        SRC_TEMP: die_temp_code_q <= {~^i_adc_data, i_adc_data};
        SRC_VON1: string_volt_on_sample_q[0] <= {~^i_adc_data, i_adc_data};
        SRC_VON2: string_volt_on_sample_q[1] <= {~^i_adc_data, i_adc_data};
        SRC_V1: string_volt_sample_q[0] <= {~^i_adc_data, i_adc_data};
        SRC_V2: string_volt_sample_q[1] <= {~^i_adc_data, i_adc_data};
        default: die_temp_code_q <= die_temp_code_q;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tsd_active_q <= 1'b0;
    end else if (die_temp_code_q.val >= i_tsd_code) begin
      tsd_active_q <= 1'b1;
    end else if (!temp_ge_thr) begin
      tsd_active_q <= 1'b0;
    end
  end

  // Flags: a set in the cycle of a clearing read wins over the clear, except for the overcurrent flag, where the clear wins.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dev_q <= '{por: 1'b1, serr: 1'b0, thermal_shutdown_flag: 1'b0, tw: 1'b0};
      str_q <= '0;
    end else if (soft_rst_q) begin
      dev_q <= '0;
      str_q <= '0;
    end else begin
      dev_q.tw <= (dev_q.tw && !rd_dev) || temp_ge_thr;
      dev_q.thermal_shutdown_flag <= (dev_q.thermal_shutdown_flag && !rd_dev) || tsd_active_q;
      dev_q.serr <= (dev_q.serr && !rd_dev) || i_serial_err;
      dev_q.por <= dev_q.por && !rd_dev;
      str_q.open <= (str_q.open & {NCH{!rd_str}}) | open_evt;
      str_q.shrt <= (str_q.shrt & {NCH{!rd_str}}) | i_short_cmp;
      str_q.oc <= (str_q.oc & {NCH{!rd_str}}) | (oc_off_q & ~{NCH{rd_str}});
      str_q.min_ton <= (str_q.min_ton & {NCH{!rd_str}}) | i_min_ton;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [1:0] lim;
    assign lim = (c == 0) ? ctrl_q.oc_lim1 : ctrl_q.oc_lim2;
    assign ch_ok[c] = ctrl_q.en[c] && !tsd_active_q && !tsd_hold_q[c] && !oc_off_q[c];

    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        oc_cnt_q[c] <= '0;
        oc_off_q[c] <= 1'b0;
      end else if (soft_rst_q || !ctrl_q.en[c]) begin
        oc_cnt_q[c] <= '0;
        oc_off_q[c] <= 1'b0;
      end else if (oc_off_q[c]) begin
        oc_off_q[c] <= !rd_str;
        oc_cnt_q[c] <= '0;
      end else if (!i_oc_above[c] || (dim_lvl[c] && !dim_lvl_q[c])) begin
        oc_cnt_q[c] <= '0;
      end else if (i_oc_tick[c]) begin
        oc_cnt_q[c] <= oc_cnt_q[c] + 3'h1;
        oc_off_q[c] <= oc_cnt_q[c] == {1'b0, lim};
      end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        tsd_hold_q[c] <= 1'b0;
        en_prev_q[c] <= 1'b0;
      end else begin
        en_prev_q[c] <= ctrl_q.en[c];
        if (tsd_active_q && !ctrl_q.auto_rcv[c]) begin
          tsd_hold_q[c] <= 1'b1;
        end else if (ctrl_q.en[c] && !en_prev_q[c]) begin
          tsd_hold_q[c] <= 1'b0;
        end
      end
    end

    // Forced sampling counts sequences since the last dimming edge or forced sample.
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        force_cnt_q[c] <= '0;
        o_force_sample[c] <= 1'b0;
      end else begin
        o_force_sample[c] <= 1'b0;
        if (forced_sample_period_q == '0 || dim_lvl[c] != dim_lvl_q[c]) begin
          force_cnt_q[c] <= '0;
        end else if (i_seq_done) begin
          if (force_cnt_q[c] == forced_sample_period_q - 9'h001) begin
            force_cnt_q[c] <= '0;
            o_force_sample[c] <= 1'b1;
          end else begin
            force_cnt_q[c] <= force_cnt_q[c] + 9'h001;
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dim_lvl_q <= '0;
      o_buck_run <= '0;
      o_short_toff <= '0;
      o_string_volt_range_sel <= '0;
    end else begin
      dim_lvl_q <= dim_lvl;
      o_buck_run <= ch_ok & ((o_mode == M_NORMAL) ? dim_lvl : {NCH{o_mode != M_INIT}});
      o_short_toff <= i_short_cmp & o_buck_run &
                      ~(i_zero_cross & {NCH{ZERO_CROSS_VARIANT}});
      o_string_volt_range_sel <= {ctrl_q.rng2, ctrl_q.rng1};
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        A_CTRL: o_reg_rdata <= {4'h0, ctrl_q};
        A_TW_THR: o_reg_rdata <= {8'h00, temp_warn_threshold_q};
        A_FORCE: o_reg_rdata <= {7'h00, forced_sample_period_q};
        A_STR_FAULT: o_reg_rdata <= {8'h00, str_q};
        A_DEV_FAULT: o_reg_rdata <= {12'h000, dev_q};
        A_STATUS: o_reg_rdata <= {10'h000, o_mode, dim_lvl, regulating};
        A_TEMP: o_reg_rdata <= {7'h00, die_temp_code_q};
        A_VON1: o_reg_rdata <= {7'h00, string_volt_on_sample_q[0]};
        A_VON1 + 8'h01: o_reg_rdata <= {7'h00, string_volt_on_sample_q[1]};
        A_V1: o_reg_rdata <= {7'h00, string_volt_sample_q[0]};
        A_V1 + 8'h01: o_reg_rdata <= {7'h00, string_volt_sample_q[1]};
        A_TON1: o_reg_rdata <= {8'h00, on_time_measure[0]};
        A_TON1 + 8'h01: o_reg_rdata <= {8'h00, on_time_measure[1]};
        default: o_reg_rdata <= '0;
      endcase
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_warn_latch: assert property (temp_ge_thr && !soft_rst_q |=> dev_q.tw)
    else $error("warning flag not set at threshold");
  a_tsd_off: assert property (tsd_active_q |=> o_buck_run == '0)
    else $error("channel running during shutdown");
  a_tsd_hyst: assert property ($fell(tsd_active_q) |-> $past(!temp_ge_thr))
    else $error("shutdown left above warning threshold");
  a_odd_parity: assert property (^die_temp_code_q && ^string_volt_sample_q[0])
    else $error("stored result has even parity");
  a_oc_hold: assert property (oc_off_q[0] && !rd_str |=> !o_buck_run[0] && oc_off_q[0])
    else $error("overcurrent hold released without read");
  a_serr_keep: assert property (i_serial_err && !soft_rst_q |=> dev_q.serr)
    else $error("serial error not latched");
  a_force_off: assert property (forced_sample_period_q == '0 |=> o_force_sample == '0)
    else $error("forced sample with zero period");
  a_short_set: assert property (i_short_cmp[1] && !soft_rst_q |=> str_q.shrt[1])
    else $error("short flag not latched");
  a_read_persist: assert property (rd_dev && temp_ge_thr && !soft_rst_q |=> dev_q.tw)
    else $error("persisting warning lost on read");

  c_tsd_cycle: cover property (tsd_active_q ##[1:1000] !tsd_active_q);
  c_oc_trip: cover property ($rose(oc_off_q[0]));
  c_forced: cover property (o_force_sample[1]);
  c_normal: cover property (o_mode == M_NORMAL);
endmodule

// ---- bench/ldd_mcu_model.sv ----
// Microcontroller model that reaches the registers with single-cycle strobes.
`timescale 1ns/1ps
module ldd_mcu_model (
  // Clock
  input wire logic i_clk,
  // Register port of the device
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [15:0] o_wdata,
  input wire logic [15:0] i_rdata
);
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_wdata = 16'h0000;
  end

  // Released address and data show the inverse of the last value.
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge i_clk);
    o_rd <= ~w;
    o_wr <= w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    @(posedge i_clk);
    #1;
    q = i_rdata;
  endtask
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the LED driver diagnostics block.
`timescale 1ns/1ps
module tb_top
  import ldd_pkg::*;
;
  logic clk, rstn, pin_n, lock, serr, av, sd;
  logic [2:0] fsel;
  ldd_src_t src;
  logic [7:0] ad, thermal_shutdown_flag;
  logic [1:0] dim, gate, shrt, zc, tick, above, mton;
  logic rd, wr;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, q;
  logic [1:0] run, toff, fs;
  logic [1:0][1:0] rng;
  ldd_mode_t mode;
  int miscompares = 0;
  int n_tests = 0;
  int nfs = 0;

  ldd_diag #(
    .OPEN_LIMIT(50),
    .INIT_LIMIT(20),
    .ZERO_CROSS_VARIANT(1'b0)
  ) i_ldd_diag (
    .i_clk(clk),
    .i_resetn(rstn),
    .i_reset_pin_n(pin_n),
    .i_failsafe_mode_sel(fsel),
    .i_otp_lock(lock),
    .i_reg_rd(rd),
    .i_reg_wr(wr),
    .i_reg_addr(addr),
    .i_reg_wdata(wdata),
    .i_serial_err(serr),
    .o_reg_rdata(rdata),
    .i_adc_valid(av),
    .i_adc_src(src),
    .i_adc_data(ad),
    .i_seq_done(sd),
    .i_tsd_code(thermal_shutdown_flag),
    .i_dim_control_input(dim),
    .i_gate_on(gate),
    .i_short_cmp(shrt),
    .i_zero_cross(zc),
    .i_oc_tick(tick),
    .i_oc_above(above),
    .i_min_ton(mton),
    .o_buck_run(run),
    .o_short_toff(toff),
    .o_force_sample(fs),
    .o_string_volt_range_sel(rng),
    .o_mode(mode)
  );

  ldd_mcu_model i_ldd_mcu_model (
    .i_clk(clk),
    .o_rd(rd),
    .o_wr(wr),
    .o_addr(addr),
    .o_wdata(wdata),
    .i_rdata(rdata)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) if (fs[0] === 1'b1) nfs++;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic rd0(input logic [7:0] a);
    i_ldd_mcu_model.acc(1'b0, a, 16'h0000, q);
  endtask

  task automatic rr(input logic [7:0] a, input logic [15:0] exp, input string nm);
    rd0(a);
    chk(nm, q, exp);
  endtask

  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    i_ldd_mcu_model.acc(1'b1, a, d, q);
  endtask

  task automatic adc(input ldd_src_t s, input logic [7:0] d);
    @(posedge clk);
    av <= 1'b1;
    src <= s;
    ad <= d;
    @(posedge clk);
    av <= 1'b0;
    cyc(3);
  endtask

  task automatic tickp;
    @(posedge clk);
    tick <= 2'b11;
    @(posedge clk);
    tick <= 2'b00;
  endtask

  task automatic seqp;
    @(posedge clk);
    sd <= 1'b1;
    @(posedge clk);
    sd <= 1'b0;
    cyc(2);
  endtask

  task automatic t_reset;
    chk("mode", {14'h0000, mode}, {14'h0000, M_INIT});
    rr(8'h11, 16'h00b3, "thr");
    rr(8'h16, 16'h0100, "temp");
    rr(8'h14, 16'h0008, "por");
    rr(8'h14, 16'h0000, "por2");
    rr(8'h30, 16'h0000, "unmap");
    chk("mode", {14'h0000, mode}, {14'h0000, M_INIT});
    cyc(20);
    chk("mode", {14'h0000, mode}, {14'h0000, M_NORMAL});
    $display("test reset done");
  endtask

  task automatic t_adc;
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      d = 8'h30 + 8'(i * 7);
      adc(ldd_src_t'(i), d);
      rr(8'h16 + 8'(i), {7'h00, ~^d, d}, "adc");
    end
    $display("test adc done");
  endtask

  task automatic t_therm;
    wrr(8'h10, 16'h01ef);
    cyc(2);
    chk("rng", {12'h000, rng}, 16'h000e);
    chk("run", {14'h0000, run}, 16'h0003);
    wrr(8'h11, 16'h0040);
    adc(SRC_TEMP, 8'h40);
    rr(8'h14, 16'h0001, "tw");
    adc(SRC_TEMP, 8'h3f);
    rd0(8'h14);
    rr(8'h14, 16'h0000, "tw0");
    adc(SRC_TEMP, 8'h90);
    chk("run", {14'h0000, run}, 16'h0000);
    rr(8'h14, 16'h0003, "tsd");
    adc(SRC_TEMP, 8'h50);
    chk("run", {14'h0000, run}, 16'h0000);
    adc(SRC_TEMP, 8'h30);
    chk("run", {14'h0000, run}, 16'h0003);
    rd0(8'h14);
    @(posedge clk);
    serr <= 1'b1;
    @(posedge clk);
    serr <= 1'b0;
    cyc(2);
    chk("run", {14'h0000, run}, 16'h0003);
    rr(8'h14, 16'h0004, "serr");
    wrr(8'h10, 16'h01e3);
    adc(SRC_TEMP, 8'h90);
    adc(SRC_TEMP, 8'h30);
    chk("hold", {14'h0000, run}, 16'h0000);
    wrr(8'h10, 16'h01e0);
    wrr(8'h10, 16'h01e3);
    cyc(2);
    chk("rcv", {14'h0000, run}, 16'h0003);
    $display("test thermal done");
  endtask

  task automatic t_oc;
    @(posedge clk);
    above <= 2'b01;
    tickp();
    cyc(2);
    chk("oc1", {14'h0000, run}, 16'h0003);
    tickp();
    cyc(2);
    chk("oc2", {14'h0000, run}, 16'h0002);
    @(posedge clk);
    above <= 2'b00;
    cyc(4);
    chk("oc3", {14'h0000, run}, 16'h0002);
    rr(8'h13, 16'h0010, "ocf");
    cyc(2);
    chk("oc4", {14'h0000, run}, 16'h0003);
    $display("test overcurrent done");
  endtask

  task automatic t_ton;
    @(posedge clk);
    gate <= 2'b01;
    repeat (20) @(posedge clk);
    gate <= 2'b00;
    rr(8'h1b, 16'h0000, "ton0");
    @(posedge clk);
    gate <= 2'b01;
    cyc(5);
    rr(8'h15, 16'h001d, "stat");
    repeat (117) @(posedge clk);
    gate <= 2'b00;
    cyc(0);
    chk("run", {14'h0000, run}, 16'h0003);
    rr(8'h15, 16'h001c, "stat0");
    rr(8'h13, 16'h0001, "open");
    rr(8'h1b, 16'h0003, "ton");
    cyc(100);
    rr(8'h1b, 16'h0003, "keep");
    $display("test on-time done");
  endtask

  task automatic t_short;
    @(posedge clk);
    shrt <= 2'b10;
    zc <= 2'b11;
    cyc(3);
    chk("run", {14'h0000, run}, 16'h0003);
    chk("toff", {14'h0000, toff}, 16'h0002);
    rr(8'h13, 16'h0008, "short");
    @(posedge clk);
    shrt <= 2'b00;
    zc <= 2'b00;
    rd0(8'h13);
    @(posedge clk);
    mton <= 2'b01;
    @(posedge clk);
    mton <= 2'b00;
    rr(8'h13, 16'h0040, "mton");
    rr(8'h13, 16'h0000, "mton0");
    $display("test short done");
  endtask

  task automatic t_force;
    wrr(8'h12, 16'h0003);
    nfs = 0;
    seqp();
    seqp();
    chk("fs0", 16'(nfs), 16'h0000);
    seqp();
    cyc(3);
    chk("fs1", 16'(nfs), 16'h0001);
    wrr(8'h12, 16'h0000);
    nfs = 0;
    repeat (4) seqp();
    chk("fs2", 16'(nfs), 16'h0000);
    $display("test forced sample done");
  endtask

  task automatic t_pin;
    wrr(8'h10, 16'h0003);
    @(posedge clk);
    fsel <= 3'h2;
    pin_n <= 1'b0;
    cyc(3);
    chk("nopin", {14'h0000, mode}, {14'h0000, M_NORMAL});
    rr(8'h10, 16'h0003, "cfg1");
    @(posedge clk);
    pin_n <= 1'b1;
    fsel <= 3'h0;
    repeat (2) @(posedge clk);
    pin_n <= 1'b0;
    cyc(3);
    chk("pin", {14'h0000, mode}, {14'h0000, M_INIT});
    rr(8'h10, 16'h0000, "cfg0");
    @(posedge clk);
    pin_n <= 1'b1;
    cyc(30);
    chk("mode", {14'h0000, mode}, {14'h0000, M_NORMAL});
    rd0(8'h14);
    chk("por3", q & 16'h0008, 16'h0000);
    @(posedge clk);
    lock <= 1'b1;
    fsel <= 3'h2;
    pin_n <= 1'b0;
    cyc(3);
    chk("fso", {14'h0000, mode}, {14'h0000, M_FAILSAFE});
    @(posedge clk);
    pin_n <= 1'b1;
    fsel <= 3'h6;
    cyc(3);
    chk("fso0", {14'h0000, mode}, {14'h0000, M_NORMAL});
    @(posedge clk);
    pin_n <= 1'b0;
    cyc(30);
    chk("sa", {14'h0000, mode}, {14'h0000, M_STANDALONE});
    $display("test reset pin done");
  endtask

  initial begin
    cyc(4000);
    miscompares++;
    give_verdict();
  end

  initial begin
    rstn = 1'b0;
    pin_n = 1'b1;
    fsel = 3'h0;
    lock = 1'b0;
    serr = 1'b0;
    av = 1'b0;
    sd = 1'b0;
    src = SRC_TEMP;
    ad = 8'h00;
    thermal_shutdown_flag = 8'h80;
    dim = 2'b11;
    gate = 2'b00;
    shrt = 2'b00;
    zc = 2'b00;
    tick = 2'b00;
    above = 2'b00;
    mton = 2'b00;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    t_reset();
    t_adc();
    t_therm();
    t_oc();
    t_ton();
    t_short();
    t_force();
    t_pin();
    give_verdict();
  end
endmodule
